// file: design/bcu_regs.svh
// Register indices, field positions, reset values and codes of the break condition unit
`ifndef BCU_REGS_SVH
`define BCU_REGS_SVH

// Register indices; the APB byte address is four times the index
`define BCU_IDX_ADDR_HIGH 28'h5FFFF90
`define BCU_IDX_ADDR_LOW 28'h5FFFF92
`define BCU_IDX_MASK_HIGH 28'h5FFFF94
`define BCU_IDX_MASK_LOW 28'h5FFFF96
`define BCU_IDX_CYCLE_SEL 28'h5FFFF98
`define BCU_IDX_IRQ_STATUS 28'h5FFFF9A
`define BCU_IDX_IRQ_MASK 28'h5FFFF9C

// Reset values
`define BCU_RST_HALF 16'h0000
`define BCU_RST_CYCLE_SEL 8'h00
`define BCU_RST_IRQ 2'h0

// Cycle-select field positions
`define BCU_POS_SOURCE 6
`define BCU_POS_ACCESS 4
`define BCU_POS_DIRECTION 2
`define BCU_POS_SIZE 0

// Operand size codes
`define BCU_SIZE_ANY 2'h0
`define BCU_SIZE_BYTE 2'h1
`define BCU_SIZE_WORD 2'h2
`define BCU_SIZE_LONG 2'h3

// Interrupt status bit positions
`define BCU_EVT_FETCH 0
`define BCU_EVT_DATA 1

// Break request priority and highest mask level that accepts it
`define BCU_BREAK_LEVEL 4'hF
`define BCU_ACCEPT_MAX_LEVEL 4'hE

`endif

// file: design/bcu_pkg.sv
// Types shared by the break condition unit
package bcu_pkg;

  // One observed bus cycle from the processor or the DMA engine master
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic isDma;
    logic isFetch;
    logic isWrite;
    logic [1:0] size;
  } bcu_cycle_type;

  // Cycle-select register fields
  typedef struct packed {
    logic [1:0] cycleSource;
    logic [1:0] accessType;
    logic [1:0] directionSel;
    logic [1:0] operandSize;
  } bcu_cond_type;

endpackage

// file: design/bcu_break_condition_unit.sv
// Break condition unit: bus cycle matcher with APB registers and break interrupt
`timescale 1ns/1ps
`default_nettype none
`include "bcu_regs.svh"

module bcu_break_condition_unit
  import bcu_pkg::*;
(
  input wire logic mclk, // System clock, 10 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic standby, // Standby mode; registers are kept
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire bcu_cycle_type busCycle, // Observed bus cycle
  input wire logic [3:0] processorMaskLevel, // Processor interrupt mask level
  input wire logic breakAccept, // Interrupt controller takes the request
  output logic breakMatch, // One-cycle pulse per matching cycle
  output logic breakOnFetch, // Last match was an instruction fetch
  output logic breakReq, // Pending break request toward the core
  output logic [3:0] breakLevel, // Priority level of the request
  output logic irq // Level interrupt from unmasked status
);

  localparam logic [27:0] IdxAddrHigh = `BCU_IDX_ADDR_HIGH;
  localparam logic [27:0] IdxAddrLow = `BCU_IDX_ADDR_LOW;
  localparam logic [27:0] IdxMaskHigh = `BCU_IDX_MASK_HIGH;
  localparam logic [27:0] IdxMaskLow = `BCU_IDX_MASK_LOW;
  localparam logic [27:0] IdxCycleSel = `BCU_IDX_CYCLE_SEL;
  localparam logic [27:0] IdxIrqStatus = `BCU_IDX_IRQ_STATUS;
  localparam logic [27:0] IdxIrqMask = `BCU_IDX_IRQ_MASK;

  logic [15:0] addrHigh_q;
  logic [15:0] addrLow_q;
  logic [15:0] maskHigh_q;
  logic [15:0] maskLow_q;
  logic [7:0] cycleSel_q;
  logic [1:0] irqStatus_q;
  logic [1:0] irqMask_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic breakMatch_q;
  logic breakOnFetch_q;
  logic breakReq_q;
  logic [3:0] breakLevel_q;
  logic irq_q;

  // Register decode: only the kept index bits take part
  wire [27:0] regIdx = paddr[29:2];
  wire [12:0] keyIdx = {regIdx[27:24], regIdx[8:0]};
  wire selAddrHigh = keyIdx == {IdxAddrHigh[27:24], IdxAddrHigh[8:0]};
  wire selAddrLow = keyIdx == {IdxAddrLow[27:24], IdxAddrLow[8:0]};
  wire selMaskHigh = keyIdx == {IdxMaskHigh[27:24], IdxMaskHigh[8:0]};
  wire selMaskLow = keyIdx == {IdxMaskLow[27:24], IdxMaskLow[8:0]};
  wire selCycleSel = keyIdx == {IdxCycleSel[27:24], IdxCycleSel[8:0]};
  wire selIrqStatus = keyIdx == {IdxIrqStatus[27:24], IdxIrqStatus[8:0]};
  wire selIrqMask = keyIdx == {IdxIrqMask[27:24], IdxIrqMask[8:0]};
  wire selAny = selAddrHigh | selAddrLow | selMaskHigh | selMaskLow | selCycleSel
    | selIrqStatus | selIrqMask;

  // One wait state: pready rises in the second access cycle
  wire accessPhase = psel & penable;
  wire commit = accessPhase & pready_q;
  wire wrCommit = commit & pwrite & selAny;
  wire [15:0] laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  function automatic logic [15:0] mergeHalf(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [15:0] lm);
    mergeHalf = (old & ~lm) | (wd & lm);
  endfunction

  wire [15:0] addrHigh_d = mergeHalf(addrHigh_q, pwdata[15:0], laneMask);
  wire [15:0] addrLow_d = mergeHalf(addrLow_q, pwdata[15:0], laneMask);
  wire [15:0] maskHigh_d = mergeHalf(maskHigh_q, pwdata[15:0], laneMask);
  wire [15:0] maskLow_d = mergeHalf(maskLow_q, pwdata[15:0], laneMask);
  // Upper byte of the cycle-select register is not stored at all
  wire [7:0] cycleSel_d = pstrb[0] ? pwdata[7:0] : cycleSel_q;
  wire [1:0] irqMask_d = pstrb[0] ? pwdata[1:0] : irqMask_q;

  wire [31:0] readMux =
    selAddrHigh ? {16'h0000, addrHigh_q} :
    selAddrLow ? {16'h0000, addrLow_q} :
    selMaskHigh ? {16'h0000, maskHigh_q} :
    selMaskLow ? {16'h0000, maskLow_q} :
    selCycleSel ? {24'h000000, cycleSel_q} :
    selIrqStatus ? {30'h00000000, irqStatus_q} :
    selIrqMask ? {30'h00000000, irqMask_q} :
    32'h00000000;

  // Break condition evaluation
  bcu_cond_type cond;
  assign cond = cycleSel_q;
  wire [31:0] breakAddr = {addrHigh_q, addrLow_q};
  wire [31:0] breakMaskBits = {maskHigh_q, maskLow_q};
  wire [31:0] bitHit;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_addr_bit
      assign bitHit[gi] = breakMaskBits[gi] | (busCycle.addr[gi] == breakAddr[gi]);
    end
  endgenerate

  wire addrHit = &bitHit;
  wire sourceHit = busCycle.isDma ? cond.cycleSource[1] : cond.cycleSource[0];
  wire accessHit = busCycle.isFetch ? cond.accessType[0] : cond.accessType[1];
  wire directionHit = busCycle.isWrite ? cond.directionSel[1] : cond.directionSel[0];
  // Fetches are words even when two instructions share one memory cycle
  wire [1:0] effSize = busCycle.isFetch ? `BCU_SIZE_WORD : busCycle.size;
  wire sizeHit = (cond.operandSize == `BCU_SIZE_ANY) | (cond.operandSize == effSize);
  // A zero source, access or direction field leaves its hit term low, so no break can occur
  wire cycleHit = busCycle.valid & addrHit & sourceHit & accessHit & directionHit
    & sizeHit;
  wire fetchHit = cycleHit & busCycle.isFetch;
  wire dataHit = cycleHit & ~busCycle.isFetch;

  // Request is taken only below the break level; otherwise it waits
  wire acceptNow = breakAccept & (processorMaskLevel <= `BCU_ACCEPT_MAX_LEVEL);
  wire breakReq_d = cycleHit | (breakReq_q & ~acceptNow);

  // Status set wins over a write-one clear in the same cycle
  wire [1:0] evtSet = {dataHit, fetchHit};
  wire [1:0] w1c = (wrCommit & selIrqStatus & pstrb[0]) ? pwdata[1:0] : 2'h0;
  wire [1:0] irqStatus_d = evtSet | (irqStatus_q & ~w1c);

  // Standby is deliberately ignored: only reset clears the conditions
  always_ff @(posedge mclk) begin
    if (srst) begin
      addrHigh_q <= `BCU_RST_HALF;
      addrLow_q <= `BCU_RST_HALF;
      maskHigh_q <= `BCU_RST_HALF;
      maskLow_q <= `BCU_RST_HALF;
      cycleSel_q <= `BCU_RST_CYCLE_SEL;
      irqMask_q <= `BCU_RST_IRQ;
    end else if (wrCommit) begin
      if (selAddrHigh) addrHigh_q <= addrHigh_d;
      if (selAddrLow) addrLow_q <= addrLow_d;
      if (selMaskHigh) maskHigh_q <= maskHigh_d;
      if (selMaskLow) maskLow_q <= maskLow_d;
      if (selCycleSel) cycleSel_q <= cycleSel_d;
      if (selIrqMask) irqMask_q <= irqMask_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= accessPhase & ~pready_q;
      pslverr_q <= accessPhase & ~pready_q & ~selAny;
      prdata_q <= (accessPhase & ~pready_q & ~pwrite) ? readMux : 32'h00000000;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      breakMatch_q <= 1'b0;
      breakOnFetch_q <= 1'b0;
      breakReq_q <= 1'b0;
      breakLevel_q <= 4'h0;
      irqStatus_q <= `BCU_RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      breakMatch_q <= cycleHit;
      if (cycleHit) breakOnFetch_q <= busCycle.isFetch;
      breakReq_q <= breakReq_d;
      breakLevel_q <= `BCU_BREAK_LEVEL;
      irqStatus_q <= irqStatus_d;
      irq_q <= |(irqStatus_d & irqMask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign breakMatch = breakMatch_q;
  assign breakOnFetch = breakOnFetch_q;
  assign breakReq = breakReq_q;
  assign breakLevel = breakLevel_q;
  assign irq = irq_q;

endmodule

`default_nettype wire

// file: bench/bcu_bus_master_model.sv
// Processor and DMA engine master bus cycle source seen by the matcher
`timescale 1ns/1ps
`default_nettype none
`include "bcu_regs.svh"
module bcu_bus_master_model import bcu_pkg::*; (
  input wire logic mclk, // System clock
  output var bcu_cycle_type busCycle // Cycle shown to the matcher
);
  initial busCycle = '0;
  // One cycle per call; released lines show the inverse except fetch, which goes low, and valid drops so a stale cycle never matches
  task automatic issue(input logic [31:0] a, input logic dma, fe, wr, input logic [1:0] sz);
    busCycle <= '{1'b1, a, dma, fe & !dma, wr & !fe, fe ? `BCU_SIZE_WORD : sz};
    @(posedge mclk);
    busCycle <= '{1'b0, ~a, !dma, 1'b0, !wr, ~sz};
  endtask
endmodule
`default_nettype wire

// file: bench/bcu_break_condition_unit_assertions.sv
// Concurrent checks on the break condition unit ports
`timescale 1ns/1ps
`default_nettype none
module bcu_break_condition_unit_assertions (
  input wire logic mclk, // Clock
  input wire logic srst, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic breakMatch, // Match pulse
  input wire logic breakReq, // Pending request
  input wire logic breakAccept, // Request taken
  input wire logic [3:0] processorMaskLevel, // Core mask level
  input wire logic [3:0] breakLevel // Request level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_level; !$past(srst) |-> breakLevel == 4'hF; endproperty
  a_level: assert property (p_level) else $error("break level wrong");
  property p_setWins; breakMatch |-> breakReq; endproperty
  a_setWins: assert property (p_setWins) else $error("match without request");
  property p_clear; breakReq && breakAccept && processorMaskLevel <= 4'hE |=> !breakReq || breakMatch; endproperty
  a_clear: assert property (p_clear) else $error("request not cleared");
  property p_hold; breakReq && !(breakAccept && processorMaskLevel <= 4'hE) |=> breakReq; endproperty
  a_hold: assert property (p_hold) else $error("pending request lost");
  property p_cause; $rose(breakReq) |-> breakMatch; endproperty
  a_cause: assert property (p_cause) else $error("request without match");
  property p_ready; psel && !penable |=> !pready ##1 pready; endproperty
  a_ready: assert property (p_ready) else $error("ready timing wrong");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_reset; $fell(srst) |-> !breakReq && !breakMatch; endproperty
  a_reset: assert property (p_reset) else $error("break after reset");
endmodule
`default_nettype wire

// file: bench/bcu_break_condition_unit_bench.sv
// Self-checking bench for the break condition unit with a reference model
`timescale 1ns/1ps
`default_nettype none
`include "bcu_regs.svh"
module bcu_break_condition_unit_bench import bcu_pkg::*; ;
  logic mclk = 1'b0, srst = 1'b1, standby = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic breakAccept = 1'b0, breakMatch, breakOnFetch, breakReq, irq, pready, pslverr, er;
  logic d, f, w, hit, of = 1'b0;
  logic [1:0] s;
  logic [3:0] processorMaskLevel = 4'hF, pstrb = 4'hF, breakLevel;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd, a, h;
  bcu_cycle_type busCycle;
  int error_cnt = 0, n_compared = 0, seed = 32'h1CC8, req = 0, stat = 0, msk = 0, k;
  logic [15:0] rv [5];
  logic [27:0] ix [5] = '{`BCU_IDX_ADDR_HIGH, `BCU_IDX_ADDR_LOW, `BCU_IDX_MASK_HIGH,
    `BCU_IDX_MASK_LOW, `BCU_IDX_CYCLE_SEL};
  initial forever #50 mclk = ~mclk;
  bcu_break_condition_unit i_bcu_break_condition_unit (.mclk(mclk), .srst(srst),
    .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busCycle(busCycle), .processorMaskLevel(processorMaskLevel), .breakAccept(breakAccept),
    .breakMatch(breakMatch), .breakOnFetch(breakOnFetch), .breakReq(breakReq),
    .breakLevel(breakLevel), .irq(irq));
  bcu_bus_master_model i_bcu_bus_master_model (.mclk(mclk), .busCycle(busCycle));
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [27:0] i, input logic [31:0] v);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, 2'b00, i, 2'b00, v};
    @(posedge mclk);
    penable <= 1'b1;
    // Ready is looked at mid-cycle, so the value taken is the one the next edge samples
    forever begin
      @(negedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    @(posedge mclk);
    {psel, penable} <= 2'b00;
  endtask
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Generous span: about 8,400 cycles are needed
  initial begin
    #5ms;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    for (k = 0; k < 5; k++) begin
      apb(1'b0, ix[k], 0);
      chk("reset value", 0, rd);
    end
    chk("level", 4'hF, breakLevel);
    apb(1'b0, 28'h5FFFFA0, 0);
    chk("unmapped", 1, er);
    repeat (150) begin
      for (k = 0; k < 5; k++) rv[k] = $random(seed);
      rv[2] &= $random(seed);
      rv[3] &= $random(seed);
      rv[4] &= 16'h00FF;
      if (rv[4][4]) rv[4][0] = 1'b0;
      msk = $random(seed) & 3;
      for (k = 0; k < 5; k++) apb(1'b1, ix[k], rv[k]);
      apb(1'b1, `BCU_IDX_IRQ_MASK, msk);
      apb(1'b1, `BCU_IDX_IRQ_STATUS, 3);
      stat = 0;
      for (k = 0; k < 5; k++) begin
        apb(1'b0, ix[k] ^ ($random(seed) & 28'h0FFFE00), 0);
        chk("register", rv[k], rd);
      end
      repeat (4) begin
        h = $random(seed);
        {d, f, w} = {h[0], !h[0] & h[1], !(!h[0] & h[1]) & h[2]};
        s = f ? 2'h2 : (h[4:3] == 2'h0 ? 2'h1 : h[4:3]);
        a = {rv[0], rv[1]} ^ (h[10] ? 0 : $random(seed) & $random(seed) & $random(seed));
        hit = ((a ^ {rv[0], rv[1]}) & ~{rv[2], rv[3]}) == 0
          && (d ? rv[4][7] : rv[4][6]) && (f ? rv[4][4] : rv[4][5])
          && (w ? rv[4][3] : rv[4][2]) && (rv[4][1:0] == 0 || rv[4][1:0] == s);
        req = hit || (req && !(h[5] && h[9:6] <= 4'hE));
        of = hit ? f : of;
        stat |= hit ? (f ? 1 : 2) : 0;
        @(posedge mclk);
        {breakAccept, processorMaskLevel, standby} <= {h[5], h[9:6], h[11]};
        i_bcu_bus_master_model.issue(a, d, f, w, s);
        breakAccept <= 1'b0;
        #1;
        chk("match", hit, breakMatch);
        chk("request", req, breakReq);
        chk("fetch flag", of, breakOnFetch);
        chk("irq", |(stat & msk), irq);
      end
    end
    print_verdict;
  end
endmodule
bind bcu_break_condition_unit bcu_break_condition_unit_assertions i_chk (.mclk(mclk),
  .srst(srst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .breakMatch(breakMatch), .breakReq(breakReq), .breakAccept(breakAccept),
  .processorMaskLevel(processorMaskLevel), .breakLevel(breakLevel));
`default_nettype wire
